// *** core/stoif_pkg.sv ***
// package of constants and types for the shut-off input and monitor logic
// assumes one 25 MHz clock and a synchronous active-high reset
// ==========================================================
package stoif_pkg;
  // ==========================================================
  // timing
  localparam int          CLK_HZ         = 25000000;
  localparam int          PULSE_MAX_US   = 1000;
  // filter must outlast the longest permitted test pulse, so add one cycle
  localparam int          PULSE_CYC      = (PULSE_MAX_US * (CLK_HZ / 1000000)) + 1;
  localparam int          CNT_W          = 16;
  localparam logic [15:0] PULSE_CNT      = 16'(PULSE_CYC);
  localparam logic [7:0]  ALARM_CODE     = 8'h3f;
  localparam logic [1:0]  IN_RESET       = 2'h0;
  localparam int          NCH            = 2;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    STOIF_RUN   = 3'h1,
    STOIF_BRAKE = 3'h2,
    STOIF_SAFE  = 3'h4
  } stoif_state_t;

  typedef struct packed {
    logic mon_a;
    logic mon_b;
    logic mon_common;
  } stoif_mon_t;

  typedef struct packed {
    logic       base_shutoff;
    logic       dyn_brake;
    logic       alarm;
    logic [7:0] alarm_code;
  } stoif_drive_t;
endpackage

// *** core/stoif_filter.sv ***
// off-pulse filter for one shut-off input
// assumes the input is already synchronised to mclk
`timescale 1ns/100ps
module stoif_filter (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic raw_on,
  output logic      filt_on
);
  import stoif_pkg::*;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  wire              hold_done = (cnt >= PULSE_CNT);

  // going on is immediate; going off needs a steady off longer than a test pulse
  assign next_cnt = raw_on ? '0 : (hold_done ? cnt : cnt + 1'b1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt     <= '0;
      filt_on <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      filt_on <= raw_on ? 1'b1 : (hold_done ? 1'b0 : filt_on);
    end
  end
endmodule

// *** core/stoif_top.sv ***
// safe torque off input, monitor and timing alarm logic
// assumes pin inputs are asynchronous levels, high when the contact is closed
`timescale 1ns/100ps
module stoif_top (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         shutoff_in_a,
  input  wire logic         shutoff_in_b,
  input  wire logic         motor_moving,
  output stoif_pkg::stoif_mon_t   monitor,
  output stoif_pkg::stoif_drive_t drive
);
  import stoif_pkg::*;

  // ==========================================================
  // three-stage synchronisers and filters
  logic [NCH-1:0] pin_raw;
  logic [NCH-1:0] s1;
  logic [NCH-1:0] s2;
  logic [NCH-1:0] s3;
  logic [NCH-1:0] stable;
  logic [NCH-1:0] ch_on;
  assign pin_raw = {shutoff_in_b, shutoff_in_a};

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1     <= IN_RESET;
      s2     <= IN_RESET;
      s3     <= IN_RESET;
      stable <= IN_RESET;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      // change counted once stages two and three agree
      stable <= (s2 & s3) | (stable & (s2 | s3));
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      stoif_filter u_filt (
        .mclk    (mclk),
        .rst     (rst),
        .raw_on  (stable[g]),
        .filt_on (ch_on[g])
      );
    end
  endgenerate

  // ==========================================================
  // decode
  wire ch_a_off   = ~ch_on[0];
  wire ch_b_off   = ~ch_on[1];
  wire any_off    = ch_a_off | ch_b_off;
  wire both_off   = ch_a_off & ch_b_off;
  wire moving_req = any_off & motor_moving;

  // motion status is same-clock logic, no synchroniser
  stoif_state_t state;
  stoif_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      STOIF_RUN: begin
        if (moving_req)
          next_state = STOIF_BRAKE;
        else if (any_off)
          next_state = STOIF_SAFE;
      end
      STOIF_BRAKE: begin
        if (!motor_moving)
          next_state = STOIF_SAFE;
      end
      STOIF_SAFE: begin
        if (!any_off)
          next_state = STOIF_RUN;
        else if (moving_req)
          next_state = STOIF_BRAKE;
      end
      default: next_state = STOIF_SAFE;
    endcase
  end

  logic alarm;
  wire  next_alarm = alarm | moving_req; // latched until reset, no clear path

  always_ff @(posedge mclk) begin
    if (rst) begin
      state      <= STOIF_SAFE;
      alarm      <= 1'b0;
      monitor    <= '{mon_a: 1'b1, mon_b: 1'b1, mon_common: 1'b1};
      drive      <= '{base_shutoff: 1'b1, dyn_brake: 1'b0, alarm: 1'b0, alarm_code: 8'h00};
    end else begin
      state              <= next_state;
      alarm              <= next_alarm;
      monitor.mon_a      <= ch_a_off;
      monitor.mon_b      <= ch_b_off;
      monitor.mon_common <= both_off;
      drive.base_shutoff <= any_off;
      drive.dyn_brake    <= (next_state == STOIF_BRAKE);
      drive.alarm        <= next_alarm;
      drive.alarm_code   <= next_alarm ? ALARM_CODE : 8'h00;
    end
  end

  // ==========================================================
  // checks
  sequence seq_off;
    any_off;
  endsequence
  mon_a_follow_a: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> monitor.mon_a == $past(ch_a_off)) else $error("monitor a wrong");
  mon_b_follow_a: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> monitor.mon_b == $past(ch_b_off)) else $error("monitor b wrong");
  mon_common_a: assert property (@(posedge mclk) disable iff (rst)
    monitor.mon_common |-> monitor.mon_a && monitor.mon_b) else $error("common on alone");
  base_off_a: assert property (@(posedge mclk) disable iff (rst)
    seq_off |=> drive.base_shutoff) else $error("drive not cut");
  base_release_a: assert property (@(posedge mclk) disable iff (rst)
    !drive.base_shutoff |-> !monitor.mon_a && !monitor.mon_b) else $error("released with off channel");
  alarm_set_a: assert property (@(posedge mclk) disable iff (rst)
    moving_req |=> drive.alarm && drive.alarm_code == 8'h3f && drive.dyn_brake) else $error("no alarm");
  alarm_hold_a: assert property (@(posedge mclk) disable iff (rst)
    drive.alarm |=> drive.alarm) else $error("alarm dropped");
  pulse_filter_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(stable[0]) && ch_on[0] |=> ch_on[0] [*8]) else $error("short pulse passed");
  ch_b_cut_a: assert property (@(posedge mclk) disable iff (rst)
    ch_b_off |=> drive.base_shutoff) else $error("b open not cut");

  // ==========================================================
  // per-channel monitor edges
  mon_a_rise_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(ch_a_off) |=> monitor.mon_a)
    else $error("monitor a not closed");
  mon_a_clear_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(ch_a_off) |=> !monitor.mon_a)
    else $error("monitor a not opened");
  mon_b_rise_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(ch_b_off) |=> monitor.mon_b)
    else $error("monitor b not closed");
  mon_b_clear_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(ch_b_off) |=> !monitor.mon_b)
    else $error("monitor b not opened");
  common_on_a: assert property (@(posedge mclk) disable iff (rst)
    both_off |=> monitor.mon_common)
    else $error("common path not on");
  common_off_a: assert property (@(posedge mclk) disable iff (rst)
    !both_off |=> !monitor.mon_common)
    else $error("common path not off");
  common_and_a: assert property (@(posedge mclk) disable iff (rst)
    monitor.mon_a && monitor.mon_b |-> monitor.mon_common)
    else $error("common path missing");

  // ==========================================================
  // power stage cut and release
  release_both_a: assert property (@(posedge mclk) disable iff (rst)
    !any_off |=> !drive.base_shutoff)
    else $error("drive not released");
  ch_a_cut_a: assert property (@(posedge mclk) disable iff (rst)
    ch_a_off |=> drive.base_shutoff)
    else $error("a open not cut");
  safe_to_run_a: assert property (@(posedge mclk) disable iff (rst)
    state == STOIF_SAFE && !any_off |=> state == STOIF_RUN)
    else $error("safe state stuck");
  sync_agree_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(stable[0]) |-> $past(s2[0] == s3[0]))
    else $error("a changed without agreement");
  sync_agree_b_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(stable[1]) |-> $past(s2[1] == s3[1]))
    else $error("b changed without agreement");

  // ==========================================================
  // off-pulse filters
  filter_on_a: assert property (@(posedge mclk) disable iff (rst)
    stable[0] |=> ch_on[0])
    else $error("a on delayed");
  filter_on_b_a: assert property (@(posedge mclk) disable iff (rst)
    stable[1] |=> ch_on[1])
    else $error("b on delayed");
  pulse_filter_b_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(stable[1]) && ch_on[1] |=> ch_on[1] [*8])
    else $error("short pulse passed on b");
  off_cause_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(ch_on[0]) |-> $past(!stable[0]))
    else $error("a dropped while on");
  off_cause_b_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(ch_on[1]) |-> $past(!stable[1]))
    else $error("b dropped while on");

  // ==========================================================
  // timing alarm and dynamic brake, built from steps
  sequence seq_moving_cut;
    any_off ##0 motor_moving;
  endsequence
  sequence seq_braking;
    drive.dyn_brake && drive.alarm;
  endsequence
  sequence seq_brake_done;
    state == STOIF_BRAKE && !motor_moving;
  endsequence
  sequence seq_still_braking;
    drive.dyn_brake && motor_moving;
  endsequence
  alarm_entry_a: assert property (@(posedge mclk) disable iff (rst)
    seq_moving_cut |=> seq_braking)
    else $error("no brake on moving cut");
  brake_end_a: assert property (@(posedge mclk) disable iff (rst)
    seq_brake_done |=> !drive.dyn_brake)
    else $error("brake not ended");
  brake_hold_a: assert property (@(posedge mclk) disable iff (rst)
    seq_still_braking |=> drive.dyn_brake)
    else $error("brake dropped early");
  alarm_cause_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(drive.alarm) |-> $past(moving_req))
    else $error("alarm without cause");
  code_value_a: assert property (@(posedge mclk) disable iff (rst)
    drive.alarm |-> drive.alarm_code == ALARM_CODE)
    else $error("alarm code wrong");
  code_zero_a: assert property (@(posedge mclk) disable iff (rst)
    !drive.alarm |-> drive.alarm_code == 8'h00)
    else $error("code without alarm");
  state_onehot_a: assert property (@(posedge mclk) disable iff (rst)
    $onehot(state))
    else $error("state not one-hot");
endmodule

// *** dv/stoif_relay.sv ***
// far-side safety relay model driving both shut-off contacts
// assumes the bench calls its tasks from one process
`timescale 1ns/100ps
module stoif_relay (
  input  wire logic mclk,
  output logic      contact_a,
  output logic      contact_b
);
  // ==========================================================
  // contacts start open, the safe state
  initial begin
    contact_a = 1'h0;
    contact_b = 1'h0;
  end
  // both contacts move on one edge
  task automatic set_both(input logic on);
    @(posedge mclk);
    contact_a <= on;
    contact_b <= on;
  endtask
  // off interval kept at or below 25000 cycles
  task automatic test_pulse(input int cyc);
    set_both(1'h0);
    repeat (cyc) @(posedge mclk);
    contact_a <= 1'h1;
    contact_b <= 1'h1;
  endtask
  // single-channel drop, a fault case on bench command only
  task automatic drop_a();
    @(posedge mclk);
    contact_a <= 1'h0;
  endtask
endmodule

// *** dv/stoif_top_tb.sv ***
// bench for the shut-off input and monitor logic
// assumes the fixed 25001-cycle off filter; run is about 50k cycles
`timescale 1ns/100ps
module stoif_top_tb;
  import stoif_pkg::*;
  logic         mclk         = 1'h0;
  logic         rst          = 1'h1;
  logic         motor_moving = 1'h0;
  logic         in_a;
  logic         in_b;
  stoif_mon_t   monitor;
  stoif_drive_t drive;
  int           failures     = 0;
  int           comparisons  = 0;
  always #20 mclk = ~mclk;
  stoif_relay i_stoif_relay (.mclk(mclk), .contact_a(in_a), .contact_b(in_b));
  stoif_top i_stoif_top (.mclk(mclk), .rst(rst), .shutoff_in_a(in_a), .shutoff_in_b(in_b),
    .motor_moving(motor_moving), .monitor(monitor), .drive(drive));
  // ==========================================================
  // helpers; sampling on the falling edge keeps races away
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    wait_cyc(3);
    check("monitor", 8'(monitor), 8'h07);
    check("base", 8'(drive.base_shutoff), 8'h01);
    check("code", drive.alarm_code, 8'h00);
  endtask
  task automatic t_release();
    i_stoif_relay.set_both(1'h1);
    wait_cyc(12);
    check("monitor", 8'(monitor), 8'h00);
    check("base", 8'(drive.base_shutoff), 8'h00);
  endtask
  task automatic t_pulse();
    i_stoif_relay.test_pulse(25000);
    wait_cyc(40);
    check("monitor", 8'(monitor), 8'h00);
    check("base", 8'(drive.base_shutoff), 8'h00);
  endtask
  task automatic t_single();
    i_stoif_relay.drop_a(); // motor at rest here
    wait_cyc(25012);
    check("monitor", 8'(monitor), 8'h04);
    check("base", 8'(drive.base_shutoff), 8'h01);
    check("alarm", 8'(drive.alarm), 8'h00);
  endtask
  task automatic t_alarm();
    @(posedge mclk);
    motor_moving <= 1'h1;
    wait_cyc(8);
    check("brake", 8'(drive.dyn_brake), 8'h01);
    check("code", drive.alarm_code, 8'h3f);
    @(posedge mclk);
    motor_moving <= 1'h0;
    wait_cyc(8);
    check("brake", 8'(drive.dyn_brake), 8'h00);
    check("alarm", 8'(drive.alarm), 8'h01);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    t_reset();
    t_release();
    t_pulse();
    t_single();
    t_alarm();
    report_and_stop();
  end
  initial begin
    #4000000;
    failures++;
    report_and_stop();
  end
endmodule
